// File: rtc_serial_slave.v
// two-wire serial slave of the rtc with flag and charge registers
// Contract
// - oscillator stop, first power-up or software stop sets status bit 7.
// - bit 7 clears only on a written 0; writing 1 does nothing.
// - alarm-2 match sets bit 1; pin asserts if enable and select are 1.
// - alarm-1 match sets bit 0; pin asserts if enable and select are 1.
// - alarm flags clear only on written 0; written 1 leaves them unchanged.
// - charger enabled only when key field bits 7..4 equal 1010.
// - diode field 01 no diode, 10 one diode; 00 and 11 disable.
// - resistor field 01 250 ohm, 10 2k, 11 4k; 00 disables.
// - charge register holds zero after power-up, path disabled.
// - transfers begin only from idle bus, both lines high.
// - data change while clock high is a control condition.
// - start is data falling while clock high.
// - stop is data rising while clock high.
// - one clock pulse per bit; transmitter changes data with clock low.
// - bytes of eight bits followed by a ninth acknowledge bit.
// - acknowledger holds data low over the whole acknowledge high phase.
// - on master not-acknowledge the device releases data for stop.
// - all bytes shift most significant bit first.
// - transfer ends with stop or repeated start.
// - works at 100 kHz and 400 kHz link clock.
// - unlimited byte count per transfer, master decides.
// - write: first byte is address, device acknowledges every byte.
// - respond only to address 1101000 plus direction bit.
// - pointer loads from first written byte, advances after each data byte.
`timescale 1ns/1ps
`include "rtc_map.vh"
module rtc_serial_slave (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda,
    output reg o_sda_oe,
    input wire i_osc_stop_evt,
    input wire i_alarm_one_evt,
    input wire i_alarm_two_evt,
    output wire o_wave_irq_pin,
    output wire o_osc_run,
    output wire [1:0] o_wave_rate,
    output reg o_charge_enable,
    output reg o_charge_diode,
    output reg [1:0] o_charge_res,
    output wire o_busy
);
    // ==========================================================
    // line sampling
    // 10 ns sampling leaves many samples per phase at 400 kHz
    wire scl_s;
    wire sda_s;
    reg scl_d_reg;
    reg sda_d_reg;
    rtc_sync2 #(.RESET_VAL(1'b1)) u_scl_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_scl),
        .o_sync(scl_s)
    );
    rtc_sync2 #(.RESET_VAL(1'b1)) u_sda_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_sda),
        .o_sync(sda_s)
    );
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    wire scl_rise = scl_s && !scl_d_reg;
    wire scl_fall = !scl_s && scl_d_reg;
    // data edges with clock high and steady are control conditions
    wire start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    wire stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // ==========================================================
    // protocol state machine
    // idle: waits for a start, ignores all clock pulses
    // addr: shifts the address byte, acknowledges only our address
    // addr_ack: holds the acknowledge, then turns the link around
    // wr: shifts data bytes; the first one loads the pointer
    // wr_ack: holds the acknowledge until the clock falls
    // rd: drives one bit per clock low phase
    // rd_ack: listens to the master's acknowledge bit
    // start and stop are checked ahead of the case, so either
    // one aborts any state; a cut frame never leaves the line held
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_ADDR_ACK = 3'd2;
    localparam ST_WR = 3'd3;
    localparam ST_WR_ACK = 3'd4;
    localparam ST_RD = 3'd5;
    localparam ST_RD_ACK = 3'd6;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] shift_reg;
    reg [7:0] shift_next;
    reg [3:0] bit_cnt_reg;
    reg [3:0] bit_cnt_next;
    reg [7:0] ptr_reg;
    reg [7:0] ptr_next;
    reg ptr_loaded_reg;
    reg ptr_loaded_next;
    reg dir_read_reg;
    reg dir_read_next;
    reg sda_low_reg;
    reg sda_low_next;
    reg nack_seen_reg;
    reg nack_seen_next;
    reg wr_en;
    wire [7:0] rdata;
    wire [7:0] control;
    wire [7:0] flags;
    wire [7:0] charge;

    always @* begin
        state_next = state_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        ptr_next = ptr_reg;
        ptr_loaded_next = ptr_loaded_reg;
        dir_read_next = dir_read_reg;
        sda_low_next = sda_low_reg;
        nack_seen_next = nack_seen_reg;
        wr_en = 1'b0;
        if (stop_cond) begin
            state_next = ST_IDLE;
            sda_low_next = 1'b0;
        end else if (start_cond) begin
            // start or repeated start reopens addressing
            state_next = ST_ADDR;
            bit_cnt_next = 4'd0;
            sda_low_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sda_low_next = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'd1;
                    end else if (scl_fall && bit_cnt_reg == 4'd8) begin
                        if (shift_reg[7:1] == `RTC_SLAVE_ADDR) begin
                            dir_read_next = shift_reg[0];
                            ptr_loaded_next = 1'b0;
                            sda_low_next = 1'b1;
                            state_next = ST_ADDR_ACK;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    // hold low until the acknowledge pulse falls
                    if (scl_fall) begin
                        bit_cnt_next = 4'd0;
                        if (dir_read_reg) begin
                            shift_next = {rdata[6:0], 1'b0};
                            sda_low_next = !rdata[7];
                            state_next = ST_RD;
                        end else begin
                            sda_low_next = 1'b0;
                            state_next = ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'd1;
                    end else if (scl_fall && bit_cnt_reg == 4'd8) begin
                        sda_low_next = 1'b1;
                        state_next = ST_WR_ACK;
                        if (!ptr_loaded_reg) begin
                            ptr_next = shift_reg;
                            ptr_loaded_next = 1'b1;
                        end else begin
                            wr_en = 1'b1;
                            ptr_next = ptr_reg + 8'd1;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_low_next = 1'b0;
                        bit_cnt_next = 4'd0;
                        state_next = ST_WR;
                    end
                end
                ST_RD: begin
                    // data bits change only after the clock falls
                    if (scl_fall) begin
                        bit_cnt_next = bit_cnt_reg + 4'd1;
                        if (bit_cnt_reg == 4'd7) begin
                            sda_low_next = 1'b0;
                            ptr_next = ptr_reg + 8'd1;
                            state_next = ST_RD_ACK;
                        end else begin
                            sda_low_next = !shift_reg[7];
                            shift_next = {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        nack_seen_next = sda_s;
                    end else if (scl_fall) begin
                        if (nack_seen_reg) begin
                            sda_low_next = 1'b0;
                            state_next = ST_IDLE;
                        end else begin
                            bit_cnt_next = 4'd0;
                            shift_next = {rdata[6:0], 1'b0};
                            sda_low_next = !rdata[7];
                            state_next = ST_RD;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    sda_low_next = 1'b0;
                end
            endcase
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'd0;
            ptr_reg <= 8'h00;
            ptr_loaded_reg <= 1'b0;
            dir_read_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            nack_seen_reg <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            ptr_reg <= ptr_next;
            ptr_loaded_reg <= ptr_loaded_next;
            dir_read_reg <= dir_read_next;
            sda_low_reg <= sda_low_next;
            nack_seen_reg <= nack_seen_next;
            o_sda_oe <= sda_low_next;
        end
    end
    // open drain: only ever pulls low
    assign o_sda = 1'b0;
    assign o_busy = (state_reg != ST_IDLE);

    // ==========================================================
    // registers
    // the write address is the pointer before it advances
    // read data is registered, so it lags a pointer change by one
    // clock; the next read bit is not needed before the next clock
    // fall, many clocks later, so the lag costs nothing
    rtc_regfile u_regs (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_en),
        .i_addr(ptr_reg),
        .i_wdata(shift_reg),
        .i_osc_stop_evt(i_osc_stop_evt),
        .i_alarm_one_evt(i_alarm_one_evt),
        .i_alarm_two_evt(i_alarm_two_evt),
        .o_rdata(rdata),
        .o_control(control),
        .o_flags(flags),
        .o_charge(charge)
    );

    // ==========================================================
    // outputs from registers
    // wave pin is active low while an enabled flag is set
    // with the select bit clear the pin stays released high here;
    // the square-wave generator is outside this block
    assign o_wave_irq_pin = !(control[`RTC_CTL_INTSEL_BIT] &&
        ((control[`RTC_CTL_ALARM_TWO_IRQ_ENABLE_BIT] && flags[`RTC_FLAG_A2_BIT]) ||
        (control[`RTC_CTL_ALARM_ONE_IRQ_ENABLE_BIT] && flags[`RTC_FLAG_A1_BIT])));
    assign o_osc_run = !control[`RTC_CTL_OSC_BIT];
    assign o_wave_rate = control[4:3];

    // the charge path only opens when key, diode and resistor fields
    // are all valid; the outputs are registered so a half-written
    // byte can never glitch the switch
    wire key_ok = (charge[`RTC_KEY_HI:`RTC_KEY_LO] == `RTC_CHARGE_KEY);
    wire [1:0] diode_pick_field = charge[`RTC_DIODE_HI:`RTC_DIODE_LO];
    wire [1:0] resistor_pick_field = charge[`RTC_RES_HI:`RTC_RES_LO];
    wire diode_ok = (diode_pick_field == `RTC_DIODE_NONE) ||
        (diode_pick_field == `RTC_DIODE_ONE);
    wire res_ok = (resistor_pick_field != 2'b00);
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_charge_enable <= 1'b0;
            o_charge_diode <= 1'b0;
            o_charge_res <= 2'b00;
        end else begin
            o_charge_enable <= key_ok && diode_ok && res_ok;
            o_charge_diode <= (diode_pick_field == `RTC_DIODE_ONE);
            o_charge_res <= (key_ok && diode_ok) ? resistor_pick_field : 2'b00;
        end
    end
endmodule

// File: rtc_map.vh
// register map, field positions, reset values and link constants for the rtc serial slave
`ifndef RTC_MAP_VH
`define RTC_MAP_VH
`define RTC_SLAVE_ADDR 7'h68
`define RTC_OFS_CONTROL 8'h0e
`define RTC_OFS_FLAGS 8'h0f
`define RTC_OFS_CHARGE 8'h10
`define RTC_FLAG_OSC_BIT 7
`define RTC_FLAG_A2_BIT 1
`define RTC_FLAG_A1_BIT 0
`define RTC_FLAGS_RESET 8'h80
`define RTC_CHARGE_RESET 8'h00
`define RTC_CONTROL_RESET 8'h18
`define RTC_CTL_OSC_BIT 7
`define RTC_CTL_INTSEL_BIT 2
`define RTC_CTL_ALARM_TWO_IRQ_ENABLE_BIT 1
`define RTC_CTL_ALARM_ONE_IRQ_ENABLE_BIT 0
`define RTC_CHARGE_KEY 4'ha
`define RTC_KEY_HI 7
`define RTC_KEY_LO 4
`define RTC_DIODE_HI 3
`define RTC_DIODE_LO 2
`define RTC_RES_HI 1
`define RTC_RES_LO 0
`define RTC_DIODE_NONE 2'b01
`define RTC_DIODE_ONE 2'b10
`define RTC_RES_250 2'b01
`define RTC_RES_2K 2'b10
`define RTC_RES_4K 2'b11
`endif

// File: rtc_sync2.v
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module rtc_sync2 #(
    parameter RESET_VAL = 1'b1
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_async,
    output wire o_sync
);
    reg meta_reg;
    reg sync_reg;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end
    assign o_sync = sync_reg;
endmodule

// File: rtc_regfile.v
// control, flag and charge registers with byte read port
`timescale 1ns/1ps
`include "rtc_map.vh"
module rtc_regfile (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_wr_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_osc_stop_evt,
    input wire i_alarm_one_evt,
    input wire i_alarm_two_evt,
    output reg [7:0] o_rdata,
    output wire [7:0] o_control,
    output wire [7:0] o_flags,
    output wire [7:0] o_charge
);
    reg [7:0] control_reg;
    reg osc_halted_flag_reg;
    reg alarm_one_flag_reg;
    reg alarm_two_flag_reg;
    reg [7:0] charge_reg;
    wire wr_flags;
    wire osc_off_write;
    assign wr_flags = i_wr_en && (i_addr == `RTC_OFS_FLAGS);
    // stopping the oscillator by software counts as a stop event
    assign osc_off_write = i_wr_en && (i_addr == `RTC_OFS_CONTROL) &&
        i_wdata[`RTC_CTL_OSC_BIT] && !control_reg[`RTC_CTL_OSC_BIT];
    // the halted flag starts set like a first power-up, the alarm flags clear; set wins over a clearing write
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            control_reg <= `RTC_CONTROL_RESET;
            osc_halted_flag_reg <= 1'b1;
            alarm_one_flag_reg <= 1'b0;
            alarm_two_flag_reg <= 1'b0;
            charge_reg <= `RTC_CHARGE_RESET;
        end else begin
            if (i_wr_en && (i_addr == `RTC_OFS_CONTROL)) begin
                control_reg <= i_wdata & 8'hbf;
            end
            if (i_wr_en && (i_addr == `RTC_OFS_CHARGE)) begin
                charge_reg <= i_wdata;
            end
            if (i_osc_stop_evt || osc_off_write) begin
                osc_halted_flag_reg <= 1'b1;
            end else if (wr_flags && !i_wdata[`RTC_FLAG_OSC_BIT]) begin
                osc_halted_flag_reg <= 1'b0;
            end
            if (i_alarm_two_evt) begin
                alarm_two_flag_reg <= 1'b1;
            end else if (wr_flags && !i_wdata[`RTC_FLAG_A2_BIT]) begin
                alarm_two_flag_reg <= 1'b0;
            end
            if (i_alarm_one_evt) begin
                alarm_one_flag_reg <= 1'b1;
            end else if (wr_flags && !i_wdata[`RTC_FLAG_A1_BIT]) begin
                alarm_one_flag_reg <= 1'b0;
            end
        end
    end
    // bits 6..2 of the flag register are constant zero
    assign o_flags = {osc_halted_flag_reg, 5'b0_0000, alarm_two_flag_reg,
        alarm_one_flag_reg};
    assign o_control = control_reg;
    assign o_charge = charge_reg;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            case (i_addr)
                `RTC_OFS_CONTROL: o_rdata <= control_reg;
                `RTC_OFS_FLAGS: o_rdata <= o_flags;
                `RTC_OFS_CHARGE: o_rdata <= charge_reg;
                default: o_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// File: rtc_serial_slave_checker.sv
// port assertions for the rtc serial slave
`timescale 1ns/1ps
module rtc_serial_slave_checker (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_scl,
    input wire i_sda,
    input wire o_sda,
    input wire o_sda_oe,
    input wire i_osc_stop_evt,
    input wire i_alarm_one_evt,
    input wire i_alarm_two_evt,
    input wire o_wave_irq_pin,
    input wire o_osc_run,
    input wire [1:0] o_wave_rate,
    input wire o_charge_enable,
    input wire o_charge_diode,
    input wire [1:0] o_charge_res,
    input wire o_busy
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // link
    a_drive_value_low: assert property (o_sda_oe |-> !o_sda)
        else $error("data drive value not low");
    a_hold_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
        else $error("data drive changed with clock high");
    a_pull_low_phase: assert property ($rose(o_sda_oe) |-> !i_scl [*2])
        else $error("data pull began outside clock low");
    a_idle_no_drive: assert property (!o_busy |-> !o_sda_oe)
        else $error("data driven while idle");
    a_start_sets_busy: assert property ($fell(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] o_busy)
        else $error("start not seen");
    a_stop_clears_busy: assert property ($rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] !o_busy)
        else $error("stop not seen");
    // ==========================================
    // charge path, then covers of ack pull, diode charge and irq pin
    a_charge_res_live: assert property (o_charge_enable |-> o_charge_res != 2'b00)
        else $error("charge enabled with no resistor");
    a_charge_off_res: assert property (!o_charge_enable |-> o_charge_res == 2'b00)
        else $error("resistor picked while charge off");
    c_ack_pull: cover property ($rose(o_sda_oe));
    c_charge_diode: cover property (o_charge_enable && o_charge_diode);
    c_irq_low: cover property (!o_wave_irq_pin);
endmodule
bind rtc_serial_slave rtc_serial_slave_checker u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_osc_stop_evt(i_osc_stop_evt),
    .i_alarm_one_evt(i_alarm_one_evt), .i_alarm_two_evt(i_alarm_two_evt),
    .o_wave_irq_pin(o_wave_irq_pin), .o_osc_run(o_osc_run), .o_wave_rate(o_wave_rate),
    .o_charge_enable(o_charge_enable), .o_charge_diode(o_charge_diode),
    .o_charge_res(o_charge_res), .o_busy(o_busy));

// File: rtc_bus_master.sv
// two-wire bus master model, 16 system clocks per link bit (160 ns)
`timescale 1ns/1ps
module rtc_bus_master (
    input wire i_ref_clk,
    input wire i_pull,
    output logic o_scl,
    output wire o_sda
);
    logic drv = 1'b1;
    initial o_scl = 1'b1;
    // pull-up: a released line reads high, never the last driven value
    assign o_sda = drv & ~i_pull;
    task tk(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // bitx moves data 4 clocks into a low phase; only start and stop move data with clock high
    task start();
        drv <= 1'b1; tk(6);
        o_scl <= 1'b1; tk(4);
        drv <= 1'b0; tk(4);
        o_scl <= 1'b0; tk(4);
    endtask
    task stop();
        drv <= 1'b0; tk(4);
        o_scl <= 1'b1; tk(4);
        drv <= 1'b1; tk(8);
    endtask
    task bitx(input logic b, output logic r);
        drv <= b; tk(4);
        o_scl <= 1'b1; tk(4);
        r = o_sda; tk(4);
        o_scl <= 1'b0; tk(4);
    endtask
    task xbyte(input logic [7:0] tx, input logic a_in, output logic [7:0] rx, output logic a);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(a_in, a);
    endtask
endmodule

// File: rtc_serial_slave_tb.sv
// self-checking bench for the rtc serial slave
`timescale 1ns/1ps
`include "rtc_map.vh"
module rtc_serial_slave_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic a1 = 1'b0;
    logic a2 = 1'b0;
    logic osc = 1'b0;
    wire scl, sda, oe, sda_o, irq_n, run, busy, c_en, c_di;
    wire [1:0] rate, c_res;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] seed = 32'h73ea_bc6a;
    logic [7:0] rb, v;
    logic [7:0] cv[$] = '{8'ha5, 8'hab, 8'ha6, 8'ha8, 8'had, 8'ha1, 8'hb9};
    initial forever #5 clk = ~clk;
    rtc_bus_master m (.i_ref_clk(clk), .i_pull(oe), .o_scl(scl), .o_sda(sda));
    rtc_serial_slave dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_o), .o_sda_oe(oe), .i_osc_stop_evt(osc), .i_alarm_one_evt(a1),
        .i_alarm_two_evt(a2), .o_wave_irq_pin(irq_n), .o_osc_run(run), .o_wave_rate(rate),
        .o_charge_enable(c_en), .o_charge_diode(c_di), .o_charge_res(c_res), .o_busy(busy));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [3:0] chg_exp(input logic [7:0] x);
        logic en;
        en = x[7:4] == `RTC_CHARGE_KEY && (x[3:2] == 2'b01 || x[3:2] == 2'b10) && x[1:0] != 0;
        return {en, en & x[3], en ? x[1:0] : 2'b00};
    endfunction
    task summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k == 50) begin
            n_fail++;
            summarize();
        end
    endtask
    task put(input logic [7:0] b, input logic ack_exp);
        logic a;
        m.xbyte(b, 1'b1, rb, a);
        chk({7'h0, a}, {7'h0, ack_exp});
    endtask
    task wr(input logic [7:0] p, input logic [7:0] d[$]);
        m.start();
        put(8'hd0, 1'b0);
        put(p, 1'b0);
        foreach (d[i]) put(d[i], 1'b0);
        m.stop();
        idle();
    endtask
    task rd(input logic [7:0] p, input logic [7:0] e[$]);
        logic a;
        m.start();
        put(8'hd0, 1'b0);
        put(p, 1'b0);
        m.start();
        put(8'hd1, 1'b0);
        foreach (e[i]) begin
            m.xbyte(8'hff, i == e.size() - 1, rb, a);
            chk(rb, e[i]);
        end
        chk({7'h0, oe}, 8'h00);
        m.stop();
        idle();
    endtask
    task pulse(input int w);
        if (w == 0) osc <= 1'b1;
        else if (w == 1) a1 <= 1'b1;
        else a2 <= 1'b1;
        @(posedge clk);
        {osc, a1, a2} <= 3'b000;
        @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, c_en, c_di, c_res}, 8'h00);
        chk({5'h00, run, rate}, 8'h07);
        rd(`RTC_OFS_FLAGS, '{8'h80, 8'h00});
        $display("test reset values done");
        // ==========================================
        // flags and interrupt pin
        wr(`RTC_OFS_FLAGS, '{8'hff});
        rd(`RTC_OFS_FLAGS, '{8'h80});
        wr(`RTC_OFS_FLAGS, '{8'h00});
        pulse(1);
        rd(`RTC_OFS_FLAGS, '{8'h01});
        wr(`RTC_OFS_CONTROL, '{8'h06});
        chk({7'h0, irq_n}, 8'h01);
        pulse(2);
        chk({7'h0, irq_n}, 8'h00);
        wr(`RTC_OFS_FLAGS, '{8'h03});
        rd(`RTC_OFS_FLAGS, '{8'h03});
        wr(`RTC_OFS_FLAGS, '{8'h01});
        rd(`RTC_OFS_FLAGS, '{8'h01});
        chk({7'h0, irq_n}, 8'h01);
        wr(`RTC_OFS_CONTROL, '{8'h01});
        chk({7'h0, irq_n}, 8'h01);
        wr(`RTC_OFS_CONTROL, '{8'h05});
        chk({7'h0, irq_n}, 8'h00);
        pulse(0);
        rd(`RTC_OFS_CONTROL, '{8'h05, 8'h81});
        chk({5'h00, run, rate}, 8'h04);
        // stopping the oscillator by software must set the halted flag again
        wr(`RTC_OFS_FLAGS, '{8'h00});
        rd(`RTC_OFS_FLAGS, '{8'h00});
        wr(`RTC_OFS_CONTROL, '{8'h98});
        chk({5'h00, run, rate}, 8'h03);
        rd(`RTC_OFS_FLAGS, '{8'h80});
        $display("test flags done");
        // ==========================================
        // foreign addresses get no acknowledge
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            m.start();
            put({7'h68 ^ {v[6:1], 1'b1}, v[0]}, 1'b1);
            m.stop();
            idle();
        end
        $display("test address done");
        // ==========================================
        // charge path: corner values then random, those at odd indices keyed
        for (int i = 0; i < 12; i++) begin
            v = i < cv.size() ? cv[i] : rnd();
            if (i >= cv.size() && i[0]) v[7:4] = 4'ha;
            wr(`RTC_OFS_CHARGE, '{v});
            chk({4'h0, c_en, c_en & c_di, c_res}, {4'h0, chg_exp(v)});
            rd(`RTC_OFS_CHARGE, '{v});
        end
        $display("test charge done");
        // ==========================================
        // reset in mid-run restores power-up values
        wr(`RTC_OFS_CHARGE, '{8'ha9});
        chk({4'h0, c_en, c_en & c_di, c_res}, {4'h0, chg_exp(8'ha9)});
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, c_en, c_di, c_res}, 8'h00);
        chk({5'h00, run, rate}, 8'h07);
        rd(`RTC_OFS_FLAGS, '{8'h80, 8'h00});
        $display("test mid-run reset done");
        summarize();
    end
endmodule
